//--- design/ecb_pkg.sv
// Package: constants, register map and carrier types of the encoder capture block
package ecb_pkg;

  // Sizes and timing
  localparam int NCH           = 4;
  localparam int CW            = 32;
  localparam int CLK_PERIOD_NS = 50;
  localparam int BP_PULSE_NS   = 200;
  localparam logic [2:0] BP_PULSE_CYC =
    3'((BP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // Global register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_MASK = 8'h08;
  localparam logic [7:0] ADDR_SHDN = 8'h0c;
  // Channel window: bit 7 set, bits 6:5 channel, bits 4:0 offset
  localparam int         CH_SEL_BIT = 7;
  localparam logic [4:0] CH_CFG   = 5'h00;
  localparam logic [4:0] CH_CMD   = 5'h04;
  localparam logic [4:0] CH_POS   = 5'h08;
  localparam logic [4:0] CH_CAP   = 5'h0c;
  localparam logic [4:0] CH_BPPOS = 5'h10;
  localparam logic [4:0] CH_BPMOD = 5'h14;
  localparam logic [4:0] CH_STS   = 5'h18;

  // Field positions
  localparam int CTRL_SDN_EN   = 0;
  localparam int CTRL_INH_HIGH = 1;
  localparam int SHDN_CLR      = 0;
  localparam int ST_CAP_LSB    = 0;
  localparam int ST_BP_LSB     = 4;
  localparam int ST_SDN        = 8;
  localparam int STW           = 9;

  // Reset values
  localparam logic [1:0]     CTRL_RST = 2'h0;
  localparam logic [STW-1:0] MASK_RST = 9'h000;
  localparam logic [CW-1:0]  BP_RST   = 32'h0000_0000;

  typedef enum logic [1:0] {BPM_ABS, BPM_MOD, BPM_REL, BPM_RSVD} ecb_bpmode_e;
  typedef enum logic [1:0] {BPA_HIGH, BPA_LOW, BPA_TOGGLE, BPA_NONE} ecb_bpact_e;

  // Channel configuration, laid out as CFG bits 10:0
  typedef struct packed {
    logic        bp_route;
    ecb_bpact_e  bp_act;
    ecb_bpmode_e bp_mode;
    logic        trig_inv;
    logic        trig_en;
    logic [3:0]  filt;
  } ecb_cfg_s;
  localparam ecb_cfg_s CFG_RST = '0;

  // Channel command strobes, laid out as CMD bits 4:0
  typedef struct packed {
    logic idx_search;
    logic out_level;
    logic out_force;
    logic cap_rearm;
    logic bp_arm;
  } ecb_cmd_s;

  // Channel status, laid out as STS bits 5:0
  typedef struct packed {
    logic idx_found;
    logic idx_busy;
    logic bp_armed;
    logic bp_out;
    logic cap_pend;
    logic trig_seen;
  } ecb_flags_s;

endpackage : ecb_pkg

//--- design/ecb_chan.sv
// One encoder channel: input filter, quadrature counter, capture and breakpoint
`timescale 1ns/1ps
module ecb_chan
  import ecb_pkg::*;
(
  // Clock and control
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            ce,
  // Synchronised pins
  input  wire logic            a_in,
  input  wire logic            b_in,
  input  wire logic            idx_in,
  input  wire logic            trig_in,
  // Software side
  input  wire ecb_cfg_s        cfg,
  input  wire ecb_cmd_s        cmd,
  input  wire logic            cap_ack,
  input  wire logic            cnt_load,
  input  wire logic [CW-1:0]   load_val,
  input  wire logic [CW-1:0]   bp_pos,
  input  wire logic [CW-1:0]   bp_mod,
  // Results
  output logic      [CW-1:0]   count,
  output logic      [CW-1:0]   cap,
  output ecb_flags_s           flags,
  output logic                 cap_ev,
  output logic                 bp_ev,
  output logic                 trig_pulse
);

  logic [2:0]    flt_reg, flt_next;
  logic [3:0]    fcnt_reg [3], fcnt_next [3];
  logic [2:0]    prv_reg, prv_next;
  logic          trp_reg, trp_next;
  logic [CW-1:0] cnt_reg, cnt_next, cap_reg, cap_next, tgt_reg, tgt_next;
  ecb_flags_s    fl_reg, fl_next;
  logic          cev_reg, cev_next, bev_reg, bev_next, tp_reg, tp_next;
  logic [2:0]    pc_reg, pc_next;
  logic          step, up, trig_edge, idx_rise, match, fire, in_win;
  logic [2:0]    raw;

  ////////////////////////////////////////////////////////////////////////////
  // Glitch filter: a new level must hold filt+1 cycles before it is used
  always_comb begin
    raw = {idx_in, b_in, a_in};
    flt_next = flt_reg;
    for (int i = 0; i < 3; i++) begin
      fcnt_next[i] = 4'h0;
      if (raw[i] != flt_reg[i]) begin
        if (fcnt_reg[i] >= cfg.filt) flt_next[i] = raw[i];
        else fcnt_next[i] = fcnt_reg[i] + 4'h1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flt_reg <= {idx_in, b_in, a_in};
      for (int i = 0; i < 3; i++) fcnt_reg[i] <= 4'h0;
    end else if (ce) begin
      flt_reg <= flt_next;
      for (int i = 0; i < 3; i++) fcnt_reg[i] <= fcnt_next[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, capture and breakpoint compare
  always_comb begin
    // One phase changing per cycle is a count; both at once is dropped
    step      = flt_reg[0] ^ prv_reg[0] ^ flt_reg[1] ^ prv_reg[1];
    up        = flt_reg[0] ^ prv_reg[1];
    idx_rise  = flt_reg[2] & ~prv_reg[2];
    trig_edge = cfg.trig_inv ? (trp_reg & ~trig_in) : (~trp_reg & trig_in);
    prv_next  = flt_reg;
    trp_next  = trig_in;
    cnt_next  = cnt_reg;
    cap_next  = cap_reg;
    tgt_next  = tgt_reg;
    fl_next   = fl_reg;
    cev_next  = 1'b0;
    bev_next  = 1'b0;
    pc_next   = pc_reg;
    tp_next   = tp_reg;
    // Position counter
    if (cnt_load) cnt_next = load_val;
    else if (fl_reg.idx_busy && idx_rise) cnt_next = '0;
    else if (step) cnt_next = up ? cnt_reg + 32'h1 : cnt_reg - 32'h1;
    // Index search: the index edge fixes the reference zero
    if (cmd.idx_search) begin
      fl_next.idx_busy  = 1'b1;
      fl_next.idx_found = 1'b0;
    end else if (fl_reg.idx_busy && idx_rise) begin
      fl_next.idx_busy  = 1'b0;
      fl_next.idx_found = 1'b1;
    end
    // Latching input: any active edge, enabled or not; set beats clear
    if (trig_edge) fl_next.trig_seen = 1'b1;
    else if (cmd.cap_rearm) fl_next.trig_seen = 1'b0;
    // Capture holds until read or re-armed; a same-cycle edge still wins
    if (trig_edge && cfg.trig_en &&
        (!fl_reg.cap_pend || cap_ack || cmd.cap_rearm)) begin
      cap_next        = cnt_reg;
      fl_next.cap_pend = 1'b1;
      cev_next        = 1'b1;
    end else if (cap_ack || cmd.cap_rearm) fl_next.cap_pend = 1'b0;
    // Modulo target walks one modulus per cycle until the count is near
    in_win = 1'b1;
    if (cfg.bp_mode == BPM_MOD && bp_mod != '0) begin
      if ($signed(cnt_reg) > $signed(tgt_reg + bp_mod)) begin
        tgt_next = tgt_reg + bp_mod;
        in_win   = 1'b0;
      end else if ($signed(cnt_reg) < $signed(tgt_reg - bp_mod)) begin
        tgt_next = tgt_reg - bp_mod;
        in_win   = 1'b0;
      end
      match = in_win && (cnt_reg == tgt_reg || cnt_reg == tgt_reg + bp_mod ||
                         cnt_reg == tgt_reg - bp_mod);
    end else begin
      match = cnt_reg == tgt_reg;
    end
    fire = fl_reg.bp_armed && match;
    if (fire) begin
      fl_next.bp_armed = 1'b0;
      bev_next         = 1'b1;
      unique case (cfg.bp_act)
        BPA_HIGH:   fl_next.bp_out = 1'b1;
        BPA_LOW:    fl_next.bp_out = 1'b0;
        BPA_TOGGLE: fl_next.bp_out = ~fl_reg.bp_out;
        BPA_NONE:   fl_next.bp_out = fl_reg.bp_out;
      endcase
      pc_next = BP_PULSE_CYC - 3'h1;
      tp_next = cfg.bp_route;
    end else if (pc_reg != 3'h0) pc_next = pc_reg - 3'h1;
    else tp_next = 1'b0;
    // Arming: relative targets are taken from the count at this moment
    if (cmd.bp_arm) begin
      fl_next.bp_armed = 1'b1;
      tgt_next = (cfg.bp_mode == BPM_REL) ? cnt_reg + bp_pos : bp_pos;
    end
    // Software drive of the output beats a compare in the same cycle
    if (cmd.out_force) fl_next.bp_out = cmd.out_level;
  end

  // Edge detectors start at the pin level so reset leaves no false edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prv_reg <= {idx_in, b_in, a_in};
      trp_reg <= trig_in;
      cnt_reg <= '0;
      cap_reg <= '0;
      tgt_reg <= '0;
      fl_reg  <= '0;
      cev_reg <= 1'b0;
      bev_reg <= 1'b0;
      pc_reg  <= 3'h0;
      tp_reg  <= 1'b0;
    end else if (ce) begin
      prv_reg <= prv_next;
      trp_reg <= trp_next;
      cnt_reg <= cnt_next;
      cap_reg <= cap_next;
      tgt_reg <= tgt_next;
      fl_reg  <= fl_next;
      cev_reg <= cev_next;
      bev_reg <= bev_next;
      pc_reg  <= pc_next;
      tp_reg  <= tp_next;
    end
  end

  assign count      = cnt_reg;
  assign cap        = cap_reg;
  assign flags      = fl_reg;
  assign cap_ev     = cev_reg;
  assign bp_ev      = bev_reg;
  assign trig_pulse = tp_reg;

endmodule : ecb_chan

//--- design/ecb_top.sv
// Top: Avalon slave, pin synchronisers, shutdown, interrupts, four channels
`timescale 1ns/1ps
module ecb_top
  import ecb_pkg::*;
(
  // Clock, reset, enable
  input  wire logic            REF_CLK,
  input  wire logic            RSTN,
  input  wire logic            CE,
  // Avalon-MM slave
  input  wire logic [7:0]      AVS_ADDRESS,
  input  wire logic            AVS_READ,
  input  wire logic            AVS_WRITE,
  input  wire logic [CW-1:0]   AVS_WRITEDATA,
  input  wire logic [3:0]      AVS_BYTEENABLE,
  output logic      [CW-1:0]   AVS_READDATA,
  output logic                 AVS_WAITREQUEST,
  // Encoder and trigger pins
  input  wire logic [NCH-1:0]  ENC_A,
  input  wire logic [NCH-1:0]  ENC_B,
  input  wire logic [NCH-1:0]  ENC_INDEX,
  input  wire logic [NCH-1:0]  TRIG_IN,
  input  wire logic            SHUTDOWN_IN,
  // Motion outputs
  output logic      [NCH-1:0]  BP_OUT,
  output logic      [NCH-1:0]  BP_TRIG_PULSE,
  output logic      [NCH-1:0]  AXIS_INHIBIT,
  output logic                 ANALOG_ZERO,
  output logic                 STEP_HALT,
  output logic                 IRQ
);

  localparam int SW = 4 * NCH + 1;

  // Byte-enable merge of write data into an old word
  function automatic logic [CW-1:0] merge(input logic [CW-1:0] old,
                                          input logic [CW-1:0] wd,
                                          input logic [3:0]    be);
    logic [CW-1:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : merge

  logic [SW-1:0]    s1_reg, s2_reg;
  logic             sdp_reg, sdp_next;
  logic             wait_reg, wait_next;
  logic [CW-1:0]    rd_reg, rd_next;
  logic             rpend_reg, rpend_next;
  logic [1:0]       ctrl_reg, ctrl_next;
  logic [STW-1:0]   stat_reg, stat_next, mask_reg, mask_next;
  logic             shut_reg, shut_next, irq_reg, irq_next;
  logic [NCH-1:0]   inh_reg, inh_next;
  ecb_cfg_s         cfg_reg [NCH], cfg_next [NCH];
  logic [CW-1:0]    bpp_reg [NCH], bpp_next [NCH];
  logic [CW-1:0]    bpm_reg [NCH], bpm_next [NCH];
  ecb_cmd_s         cmd [NCH];
  logic [NCH-1:0]   cap_ack, cnt_load, cap_ev, bp_ev, tpulse;
  logic [CW-1:0]    count [NCH], cap [NCH];
  ecb_flags_s       flags [NCH];
  logic             req, done, wr, rd, is_ch, sd_rise, sd_ev;
  logic [1:0]       ch;
  logic [4:0]       off;
  logic [CW-1:0]    wd;

  ////////////////////////////////////////////////////////////////////////////
  // Two-stage synchronisers for every pin; stage one feeds stage two only
  // No reset: the stages fill with pin levels while reset is held
  always_ff @(posedge REF_CLK) begin
    if (CE) begin
      s1_reg <= {SHUTDOWN_IN, TRIG_IN, ENC_INDEX, ENC_B, ENC_A};
      s2_reg <= s1_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Channels
  for (genvar i = 0; i < NCH; i++) begin : g_ch
    ecb_chan u_chan (
      .clk        (REF_CLK),
      .rst_n      (RSTN),
      .ce         (CE),
      .a_in       (s2_reg[i]),
      .b_in       (s2_reg[NCH + i]),
      .idx_in     (s2_reg[2 * NCH + i]),
      .trig_in    (s2_reg[3 * NCH + i]),
      .cfg        (cfg_reg[i]),
      .cmd        (cmd[i]),
      .cap_ack    (cap_ack[i]),
      .cnt_load   (cnt_load[i]),
      .load_val   (wd),
      .bp_pos     (bpp_reg[i]),
      .bp_mod     (bpm_reg[i]),
      .count      (count[i]),
      .cap        (cap[i]),
      .flags      (flags[i]),
      .cap_ev     (cap_ev[i]),
      .bp_ev      (bp_ev[i]),
      .trig_pulse (tpulse[i])
    );
    assign BP_OUT[i]        = flags[i].bp_out;
    assign BP_TRIG_PULSE[i] = tpulse[i];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses:
  //   0x00 control: 0 shutdown enable, 1 inhibit high
  //   0x04 status: 3:0 capture, 7:4 match, 8 shutdown
  //   0x08 interrupt mask, status layout
  //   0x0c shutdown: bit 0 latched, write 1 clears
  //   0x80 + 0x20 * n: channel n window
  //   +0x00 settings: 3:0 filter, 4 trigger on
  //         5 falling edge, 7:6 mode, 9:8 action
  //         10 route match to trigger line
  //   +0x04 strobes: 0 arm, 1 re-arm capture
  //         2 force, 3 level, 4 index search
  //   +0x08 count, a write loads it
  //   +0x0c captured count
  //   +0x10 target, +0x14 modulus
  //   +0x18 flags: 0 edge seen, 1 pending
  //         2 output, 3 armed, 4 busy, 5 found
  // Status reads clear only the bits returned.
  // Unmapped reads give zero; writes drop.
  // Strobes and shutdown clear need lane 0.
  // Every transfer has one fixed wait cycle;
  // a fixed answer keeps decode off the read
  // path, at the cost of a cycle per access.
  // Requests must stay stable until wait is
  // seen low; a request that changes in the
  // middle of a transfer is not detected.
  // A capture is freed by a read only if it
  // was pending when the data was taken, so
  // one landing in the wait cycle survives.
  // Shutdown clear and a new pin edge in one
  // cycle leave shutdown set.
  // Inhibit lags the halt outputs one cycle.
  // Halt outputs only flag the drive stages.
  // Settings take effect the cycle after the
  // write; change a filter only while quiet.
  // Count wraps silently on overflow.
  // After a count load the modulo target
  // needs a few cycles to catch up.
  // Edge detectors load the synchronised
  // level in reset: no false edge after it.
  // Bus decode and strobes; a request completes the cycle after it is seen
  always_comb begin
    req   = AVS_READ | AVS_WRITE;
    done  = req & ~wait_reg;
    wr    = AVS_WRITE & done;
    rd    = AVS_READ & done;
    is_ch = AVS_ADDRESS[CH_SEL_BIT];
    ch    = AVS_ADDRESS[6:5];
    off   = AVS_ADDRESS[4:0];
    wd    = merge(count[ch], AVS_WRITEDATA, AVS_BYTEENABLE);
    for (int i = 0; i < NCH; i++) begin
      cmd[i]      = wr && is_ch && ch == 2'(i) && off == CH_CMD
                    ? ecb_cmd_s'(5'(merge('0, AVS_WRITEDATA, AVS_BYTEENABLE)))
                    : '0;
      cnt_load[i] = wr && is_ch && ch == 2'(i) && off == CH_POS;
      // Only a capture the reader actually saw is acknowledged
      cap_ack[i]  = rd && is_ch && ch == 2'(i) && off == CH_CAP && rpend_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: waitrequest low for one cycle, read data registered
  always_comb begin
    wait_next  = ~(req & wait_reg);
    rd_next    = rd_reg;
    rpend_next = rpend_reg;
    if (req && wait_reg) begin
      rd_next    = '0;
      rpend_next = flags[ch].cap_pend;
      if (is_ch) begin
        unique case (off)
          CH_CFG:   rd_next = CW'(cfg_reg[ch]);
          CH_POS:   rd_next = count[ch];
          CH_CAP:   rd_next = cap[ch];
          CH_BPPOS: rd_next = bpp_reg[ch];
          CH_BPMOD: rd_next = bpm_reg[ch];
          CH_STS:   rd_next = CW'(flags[ch]);
          default:  rd_next = '0;
        endcase
      end else begin
        unique case (AVS_ADDRESS)
          ADDR_CTRL: rd_next = CW'(ctrl_reg);
          ADDR_STAT: rd_next = CW'(stat_reg);
          ADDR_MASK: rd_next = CW'(mask_reg);
          ADDR_SHDN: rd_next = CW'(shut_reg);
          default:   rd_next = '0;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers and channel settings
  always_comb begin
    ctrl_next = ctrl_reg;
    mask_next = mask_reg;
    for (int i = 0; i < NCH; i++) begin
      cfg_next[i] = cfg_reg[i];
      bpp_next[i] = bpp_reg[i];
      bpm_next[i] = bpm_reg[i];
    end
    if (wr && !is_ch && AVS_ADDRESS == ADDR_CTRL)
      ctrl_next = 2'(merge(CW'(ctrl_reg), AVS_WRITEDATA, AVS_BYTEENABLE));
    if (wr && !is_ch && AVS_ADDRESS == ADDR_MASK)
      mask_next = STW'(merge(CW'(mask_reg), AVS_WRITEDATA, AVS_BYTEENABLE));
    if (wr && is_ch) begin
      unique case (off)
        CH_CFG:   cfg_next[ch] = ecb_cfg_s'(11'(merge(CW'(cfg_reg[ch]), AVS_WRITEDATA,
                                                      AVS_BYTEENABLE)));
        CH_BPPOS: bpp_next[ch] = merge(bpp_reg[ch], AVS_WRITEDATA, AVS_BYTEENABLE);
        CH_BPMOD: bpm_next[ch] = merge(bpm_reg[ch], AVS_WRITEDATA, AVS_BYTEENABLE);
        default:  ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown, interrupt status and motion outputs
  always_comb begin
    sdp_next = s2_reg[SW-1];
    // A level already high at enable or reset never trips: edge only
    sd_rise  = s2_reg[SW-1] & ~sdp_reg;
    sd_ev    = sd_rise & ctrl_reg[CTRL_SDN_EN];
    shut_next = shut_reg;
    if (wr && !is_ch && AVS_ADDRESS == ADDR_SHDN && AVS_BYTEENABLE[0] &&
        AVS_WRITEDATA[SHDN_CLR]) shut_next = 1'b0;
    if (sd_ev) shut_next = 1'b1;
    inh_next = {NCH{~(shut_reg ^ ctrl_reg[CTRL_INH_HIGH])}};
    // Clear only bits the reader saw; new events in that cycle survive
    stat_next = stat_reg;
    if (rd && !is_ch && AVS_ADDRESS == ADDR_STAT) stat_next = stat_reg & ~rd_reg[STW-1:0];
    stat_next[ST_CAP_LSB +: NCH] = stat_next[ST_CAP_LSB +: NCH] | cap_ev;
    stat_next[ST_BP_LSB +: NCH]  = stat_next[ST_BP_LSB +: NCH] | bp_ev;
    stat_next[ST_SDN]            = stat_next[ST_SDN] | sd_ev;
    irq_next = |(stat_next & mask_reg);
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      sdp_reg   <= s2_reg[SW-1];
      wait_reg  <= 1'b1;
      rd_reg    <= '0;
      rpend_reg <= 1'b0;
      ctrl_reg  <= CTRL_RST;
      mask_reg  <= MASK_RST;
      stat_reg  <= '0;
      shut_reg  <= 1'b0;
      inh_reg   <= {NCH{1'b1}};
      irq_reg   <= 1'b0;
      for (int i = 0; i < NCH; i++) begin
        cfg_reg[i] <= CFG_RST;
        bpp_reg[i] <= BP_RST;
        bpm_reg[i] <= BP_RST;
      end
    end else if (CE) begin
      sdp_reg   <= sdp_next;
      wait_reg  <= wait_next;
      rd_reg    <= rd_next;
      rpend_reg <= rpend_next;
      ctrl_reg  <= ctrl_next;
      mask_reg  <= mask_next;
      stat_reg  <= stat_next;
      shut_reg  <= shut_next;
      inh_reg   <= inh_next;
      irq_reg   <= irq_next;
      for (int i = 0; i < NCH; i++) begin
        cfg_reg[i] <= cfg_next[i];
        bpp_reg[i] <= bpp_next[i];
        bpm_reg[i] <= bpm_next[i];
      end
    end
  end

  // Analog zero and step halt follow the latched shutdown directly
  assign AVS_READDATA    = rd_reg;
  assign AVS_WAITREQUEST = wait_reg;
  assign AXIS_INHIBIT    = inh_reg;
  assign ANALOG_ZERO     = shut_reg;
  assign STEP_HALT       = shut_reg;
  assign IRQ             = irq_reg;

endmodule : ecb_top

//--- verif/ecb_chk_sva.sv
// Checker: port timing properties of the encoder capture block
`timescale 1ns/1ps
module ecb_chk
  import ecb_pkg::*;
(
  // Clock and reset
  input wire logic           REF_CLK,
  input wire logic           RSTN,
  // Watched ports
  input wire logic           AVS_READ,
  input wire logic           AVS_WRITE,
  input wire logic [CW-1:0]  AVS_READDATA,
  input wire logic           AVS_WAITREQUEST,
  input wire logic           SHUTDOWN_IN,
  input wire logic [NCH-1:0] BP_TRIG_PULSE,
  input wire logic           ANALOG_ZERO,
  input wire logic           STEP_HALT,
  input wire logic           IRQ
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  logic       sd_reg;
  logic [3:0] age_reg, age_next;
  // Cycles since the pin rose; saturates so a static high never looks recent
  always_comb begin
    age_next = (age_reg == 4'hf) ? age_reg : age_reg + 4'h1;
    if (SHUTDOWN_IN && !sd_reg) age_next = 4'h0;
  end
  always_ff @(posedge REF_CLK) begin
    sd_reg  <= SHUTDOWN_IN;
    age_reg <= RSTN ? age_next : 4'hf;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake and readback
  sequence s_pulse;
    BP_TRIG_PULSE[1] [*4] ##1 !BP_TRIG_PULSE[1];
  endsequence
  a_wait_one: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer late");
  a_wait_short: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("wait low too long");
  a_rd_hold: assert property (AVS_WAITREQUEST && !AVS_READ && !AVS_WRITE |=> $stable(AVS_READDATA))
    else $error("read data moved while idle");
  // Motion outputs
  // Channel 1 is the one whose match the bench routes to the line
  a_pulse_len: assert property ($rose(BP_TRIG_PULSE[1]) |-> s_pulse)
    else $error("trigger pulse length wrong");
  a_halt_pair: assert property (ANALOG_ZERO == STEP_HALT)
    else $error("halt outputs differ");
  a_shdn_edge: assert property ($rose(ANALOG_ZERO) |-> age_reg < 4'h8)
    else $error("shutdown without pin edge");
  a_halt_clear: assert property ($fell(ANALOG_ZERO) |-> !$past(AVS_WAITREQUEST) ||
    !$past(AVS_WAITREQUEST, 2)) else $error("shutdown dropped without bus write");
  a_irq_clear: assert property ($fell(IRQ) |-> !AVS_WAITREQUEST ||
    !$past(AVS_WAITREQUEST) || !$past(AVS_WAITREQUEST, 2)) else $error("irq dropped alone");
endmodule : ecb_chk
bind ecb_top ecb_chk chk_u (.REF_CLK, .RSTN, .AVS_READ, .AVS_WRITE, .AVS_READDATA,
  .AVS_WAITREQUEST, .SHUTDOWN_IN, .BP_TRIG_PULSE, .ANALOG_ZERO, .STEP_HALT, .IRQ);

//--- verif/ecb_enc_model.sv
// Partner: four quadrature encoders stepped by command
`timescale 1ns/1ps
module ecb_enc_model
  import ecb_pkg::*;
(
  // Clock, reset and step commands
  input  wire logic           clk,
  input  wire logic           rst_n,
  input  wire logic [NCH-1:0] up,
  input  wire logic [NCH-1:0] dn,
  // Encoder phases
  output logic      [NCH-1:0] pha,
  output logic      [NCH-1:0] phb
);
  logic [NCH-1:0][1:0] st_reg, st_next;
  // One quarter step per command, so only one phase moves at a time
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      st_next[i] = st_reg[i] + {1'b0, up[i]} - {1'b0, dn[i]};
      pha[i]     = st_reg[i][0] ^ st_reg[i][1];
      phb[i]     = st_reg[i][1];
    end
  end
  always_ff @(posedge clk) st_reg <= rst_n ? st_next : '0;
endmodule : ecb_enc_model

//--- verif/tb.sv
// Testbench: counting, capture, breakpoint and shutdown at the pins
`timescale 1ns/1ps
module tb
  import ecb_pkg::*;
;
  typedef struct {int ch; int n; logic [CW-1:0] exp;} ecb_row_s;
  logic           REF_CLK, RSTN, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, SHUTDOWN_IN;
  logic           IRQ, ANALOG_ZERO, STEP_HALT;
  logic [7:0]     AVS_ADDRESS;
  logic [CW-1:0]  AVS_WRITEDATA, AVS_READDATA, rd;
  logic [NCH-1:0] up, dn, ENC_A, ENC_B, TRIG_IN, BP_OUT, BP_TRIG_PULSE, AXIS_INHIBIT;
  logic [NCH-1:0] ENC_INDEX;
  int             num_errors, n_compared;
  ecb_row_s       rows [4] = '{'{0, 5, 32'h5}, '{0, -8, 32'hffff_fffd},
                               '{1, 3, 32'h3}, '{3, -1, 32'hffff_ffff}};
  ecb_top dut_u (.REF_CLK, .RSTN, .CE(1'b1), .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE(4'hf), .AVS_READDATA, .AVS_WAITREQUEST, .ENC_A, .ENC_B,
    .ENC_INDEX, .TRIG_IN, .SHUTDOWN_IN, .BP_OUT, .BP_TRIG_PULSE, .AXIS_INHIBIT,
    .ANALOG_ZERO, .STEP_HALT, .IRQ);
  ecb_enc_model enc_u (.clk(REF_CLK), .rst_n(RSTN), .up, .dn, .pha(ENC_A), .phb(ENC_B));
  ////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    REF_CLK = 1'b0;
    forever #25 REF_CLK = ~REF_CLK;
  end
  function automatic logic [7:0] ca(input int ch, input logic [4:0] off);
    return {1'b1, 2'(ch), off};
  endfunction : ca
  task automatic chk(input string what, input logic [CW-1:0] seen, input logic [CW-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic tick(input int n);
    repeat (n) @(posedge REF_CLK);
  endtask : tick
  // One bus transfer; the request stands until wait is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [CW-1:0] d);
    int n;
    n = 0;
    @(posedge REF_CLK);
    AVS_ADDRESS   <= a;
    AVS_WRITE     <= w;
    AVS_READ      <= !w;
    AVS_WRITEDATA <= d;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    rd = AVS_READDATA;
    AVS_READ  <= 1'b0;
    AVS_WRITE <= 1'b0;
    if (n >= 20) begin
      num_errors++;
      tally_and_finish();
    end
  endtask : bus
  // Steps spaced five cycles apart, well beyond the filter hold time
  task automatic move(input int ch, input int n);
    repeat (n < 0 ? -n : n) begin
      @(posedge REF_CLK);
      if (n > 0) up[ch] <= 1'b1;
      else dn[ch] <= 1'b1;
      @(posedge REF_CLK);
      up <= '0;
      dn <= '0;
      tick(3);
    end
    tick(8);
  endtask : move
  task automatic bp(input logic [CW-1:0] cfg, pos, md, input int n, input logic ex);
    bus(1'b1, ca(1, CH_CFG), cfg);
    bus(1'b1, ca(1, CH_BPPOS), pos);
    bus(1'b1, ca(1, CH_BPMOD), md);
    bus(1'b1, ca(1, CH_CMD), 32'h1);
    move(1, n);
    chk("bp_out", 32'(BP_OUT[1]), 32'(ex));
  endtask : bp
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {RSTN, AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA, up, dn, ENC_INDEX} = '0;
    TRIG_IN     = 4'hf;
    SHUTDOWN_IN = 1'b1;
    num_errors  = 0;
    n_compared  = 0;
    tick(10);
    RSTN <= 1'b1;
    chk("inhibit", 32'(AXIS_INHIBIT), 32'hf);
    chk("irq", 32'(IRQ), 32'h0);
    bus(1'b0, 8'h40, '0);
    chk("unmapped", rd, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      move(rows[i].ch, rows[i].n);
      bus(1'b0, ca(rows[i].ch, CH_POS), '0);
      chk("count", rd, rows[i].exp);
    end
    $display("count test done");
    // Index search on channel 0 behind a filter of four
    bus(1'b1, ca(0, CH_CFG), 32'h4);
    bus(1'b1, ca(0, CH_CMD), 32'h10);
    ENC_INDEX[0] <= 1'b1;
    tick(2);
    ENC_INDEX[0] <= 1'b0;
    tick(8);
    bus(1'b0, ca(0, CH_POS), '0);
    chk("count", rd, 32'hffff_fffd);
    ENC_INDEX[0] <= 1'b1;
    tick(12);
    bus(1'b0, ca(0, CH_STS), '0);
    chk("sts", 32'(rd[5:4]), 32'h2);
    bus(1'b0, ca(0, CH_POS), '0);
    chk("count", rd, 32'h0);
    ENC_INDEX[0] <= 1'b0;
    $display("index test done");
    // Falling-edge capture on channel 2, a second edge while pending
    bus(1'b1, ADDR_MASK, 32'h4);
    bus(1'b1, ca(2, CH_POS), 32'h1234);
    bus(1'b1, ca(2, CH_CFG), 32'h30);
    TRIG_IN[2] <= 1'b0;
    tick(8);
    chk("irq", 32'(IRQ), 32'h1);
    bus(1'b0, ca(2, CH_STS), '0);
    chk("sts", 32'(rd[1:0]), 32'h3);
    move(2, 2);
    TRIG_IN[2] <= 1'b1;
    tick(4);
    TRIG_IN[2] <= 1'b0;
    tick(8);
    bus(1'b0, ca(2, CH_CAP), '0);
    chk("cap", rd, 32'h1234);
    bus(1'b0, ADDR_STAT, '0);
    chk("stat", 32'(rd[3:0]), 32'h4);
    tick(3);
    chk("irq", 32'(IRQ), 32'h0);
    TRIG_IN[2] <= 1'b1;
    tick(8);
    bus(1'b0, ca(2, CH_STS), '0);
    chk("sts", 32'(rd[1:0]), 32'h1);
    $display("capture test done");
    bp(32'h400, 32'h5, 32'h0, 2, 1'b1);
    bp(32'h580, 32'h3, 32'h0, 3, 1'b0);
    bp(32'h640, 32'h2, 32'h4, 2, 1'b1);
    move(1, 4);
    chk("bp_out", 32'(BP_OUT[1]), 32'h1);
    bus(1'b1, ca(1, CH_CMD), 32'h4);
    tick(2);
    chk("bp_out", 32'(BP_OUT[1]), 32'h0);
    bus(1'b1, ca(1, CH_CMD), 32'hc);
    tick(2);
    chk("bp_out", 32'(BP_OUT[1]), 32'h1);
    $display("breakpoint test done");
    bus(1'b1, ADDR_CTRL, 32'h1);
    tick(8);
    chk("halt", 32'(ANALOG_ZERO), 32'h0);
    SHUTDOWN_IN <= 1'b0;
    tick(4);
    SHUTDOWN_IN <= 1'b1;
    tick(8);
    chk("halt", 32'({ANALOG_ZERO, STEP_HALT, AXIS_INHIBIT}), 32'h30);
    bus(1'b1, ADDR_SHDN, 32'h1);
    tick(3);
    chk("halt", 32'(ANALOG_ZERO), 32'h0);
    $display("shutdown test done");
    tally_and_finish();
  end
endmodule : tb
